//--- hw/acc_calib.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module acc_calib #(
  parameter int CAL_CYCLES = acc_pkg::ACC_CAL_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        cal_trigger_pin,
  input  wire logic        sample_strobe,
  input  wire logic [47:0] core_data,
  output logic [47:0]      channel_data,
  output logic [5:0]       core_cal_active,
  output logic [5:0]       core_online,
  output logic             offset_cal_active,
  output logic             cal_busy
);
  import acc_pkg::*;

  typedef struct packed {
    acc_state_t  st;
    logic [15:0] cnt;
    logic        sw_trig;
    logic        trg_sel;
    logic        bg_en;
    logic        fg_os;
    logic        bg_os;
    logic        trig_q;
    logic        swap_req;
    logic [1:0]  rot;
    logic        ph;
    logic [7:0]  srcdly;
    logic [7:0]  muxdly;
    logic [ACC_NTRIM*8-1:0] trim;
    logic        aw_got;
    logic        w_got;
    logic [11:0] aw_a;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [47:0] chan;
    logic [5:0]  cal_act;
    logic [5:0]  online;
    logic        os_act;
    logic        busy;
  } acc_calib_s_t;

  acc_calib_s_t s;
  acc_calib_s_t next_s;
  logic         trig;
  logic         trig_rise;
  logic [11:0]  lane_sel [4];
  logic [4:0]   trim_idx;
  logic [2:0]   bg_home;
  logic [2:0]   bg_spare;

  // home core of the lane under rotation and the spare of its pair
  assign bg_home  = (s.rot < 2'd2) ? 3'(s.rot) : 3'(s.rot) + 3'd2;
  assign bg_spare = (s.rot < 2'd2) ? 3'd2 : 3'd3;

  // ****************************************************************
  // trigger selection
  // ****************************************************************
  // one-bit select of pin or software bit; edge starts foreground
  assign trig      = s.trg_sel ? cal_trigger_pin : s.sw_trig;
  assign trig_rise = trig & ~s.trig_q;

  // ****************************************************************
  // output routing per lane
  // ****************************************************************
  // lanes A,B use spare 2; lanes C,D use spare 3 while their home
  // core is offline; the swap only takes effect on the next strobe
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      localparam int HOME  = (g < 2) ? g : g + 2;
      localparam int SPARE = (g < 2) ? 2 : 3;
      assign lane_sel[g] = (s.st == ACC_BG_CAL) && s.ph
        && s.rot == 2'(g)
        ? core_data[SPARE*12 +: 12] : core_data[HOME*12 +: 12];
    end
  endgenerate

  assign trim_idx = 5'((s.aw_a - ACC_OFS_TRIM) >> 2);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [4:0] ridx;
    ridx   = 5'((araddr - ACC_OFS_TRIM) >> 2);
    next_s = s;
    next_s.trig_q = trig;
    // sequencer
    case (s.st)
      ACC_FG_CAL: begin
        next_s.online  = 6'h00;
        next_s.cal_act = 6'h33;
        next_s.busy    = 1'b1;
        if (s.cnt == 16'(CAL_CYCLES - 1)) begin
          next_s.cnt = 16'h0000;
          next_s.st  = s.fg_os ? ACC_FG_OS : ACC_RUN;
        end else begin
          next_s.cnt = s.cnt + 16'h0001;
        end
      end
      ACC_FG_OS: begin
        next_s.os_act = 1'b1;
        if (s.cnt == 16'(ACC_OS_CYCLES - 1)) begin
          next_s.cnt    = 16'h0000;
          next_s.os_act = 1'b0;
          next_s.st     = ACC_RUN;
        end else begin
          next_s.cnt = s.cnt + 16'h0001;
        end
      end
      ACC_RUN: begin
        next_s.busy    = 1'b0;
        next_s.cal_act = 6'h00;
        next_s.os_act  = 1'b0;
        next_s.online  = 6'h33;
        if (s.bg_en) begin
          // spare of the lane to be released calibrates alone
          next_s.st  = ACC_BG_CAL;
          next_s.cnt = 16'h0000;
        end else if (trig_rise) begin
          next_s.st  = ACC_FG_CAL;
          next_s.cnt = 16'h0000;
        end
      end
      ACC_BG_CAL: begin
        // active lanes keep converting while the core calibrates
        next_s.busy = 1'b1;
        next_s.os_act  = s.bg_os;
        next_s.cal_act = 6'h00;
        next_s.online  = 6'h33;
        // phase 0 trims the spare, phase 1 the home core it replaces
        if (s.ph) begin
          next_s.cal_act[bg_home]  = 1'b1;
          next_s.online[bg_home]   = 1'b0;
          next_s.online[bg_spare]  = 1'b1;
        end else begin
          next_s.cal_act[bg_spare] = 1'b1;
        end
        if (s.cnt < 16'(CAL_CYCLES - 1)) begin
          next_s.cnt = s.cnt + 16'h0001;
        end else if (sample_strobe) begin
          // exchange only on a sample boundary
          next_s.cnt  = 16'h0000;
          next_s.ph   = ~s.ph;
          if (s.ph) next_s.rot = s.rot + 2'd1;
          if (!s.bg_en) begin
            next_s.st = ACC_RUN;
            next_s.ph = 1'b0;
          end
        end
      end
      default: next_s.st = ACC_FG_CAL;
    endcase
    // output samples; foreground holds mid-code
    if (s.st == ACC_FG_CAL || s.st == ACC_FG_OS) begin
      next_s.chan = {4{ACC_MID_CODE}};
    end else if (sample_strobe) begin
      next_s.chan = {lane_sel[3], lane_sel[2], lane_sel[1], lane_sel[0]};
    end
    // axi write: address and data in either order
    next_s.bvalid = s.bvalid & ~bready;
    if (awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_a   = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.w_d   = wdata;
      next_s.w_s   = wstrb;
    end
    next_s.awready = ~next_s.aw_got & ~s.bvalid;
    next_s.wready  = ~next_s.w_got & ~s.bvalid;
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = ACC_OKAY;
      next_s.awready = 1'b0;
      next_s.wready  = 1'b0;
      if (s.w_s[0]) begin
        if (s.aw_a == ACC_OFS_CTRL) begin
          next_s.sw_trig = s.w_d[ACC_B_SWTRIG];
          next_s.trg_sel = s.w_d[ACC_B_TRGSEL];
          next_s.bg_en   = s.w_d[ACC_B_BGEN];
          next_s.fg_os   = s.w_d[ACC_B_FGOS];
          next_s.bg_os   = s.w_d[ACC_B_BGOS];
        end else if (s.aw_a == ACC_OFS_SRCDLY) begin
          next_s.srcdly = s.w_d[7:0];
        end else if (s.aw_a == ACC_OFS_MUXDLY) begin
          next_s.muxdly = s.w_d[7:0];
        end else if (s.aw_a >= ACC_OFS_TRIM
                     && s.aw_a < ACC_OFS_TRIM + 12'(4 * ACC_NTRIM)
                     && trim_idx < 5'(ACC_NTRIM)) begin
          next_s.trim[trim_idx*8 +: 8] = s.w_d[7:0];
        end else if (s.aw_a != ACC_OFS_STATUS) begin
          next_s.bresp = ACC_SLVERR;
        end
      end
    end
    // axi read
    next_s.rvalid  = s.rvalid & ~rready;
    next_s.arready = ~next_s.rvalid & ~(arvalid & s.arready);
    if (arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = ACC_OKAY;
      next_s.rdata  = 32'h0000_0000;
      if (araddr == ACC_OFS_CTRL) begin
        next_s.rdata[4:0] = {s.bg_os, s.fg_os, s.bg_en,
                             s.trg_sel, s.sw_trig};
      end else if (araddr == ACC_OFS_STATUS) begin
        next_s.rdata[19:0] = {s.rot, s.online, s.cal_act,
                              s.st, s.os_act, s.busy};
      end else if (araddr == ACC_OFS_SRCDLY) begin
        next_s.rdata[7:0] = s.srcdly;
      end else if (araddr == ACC_OFS_MUXDLY) begin
        next_s.rdata[7:0] = s.muxdly;
      end else if (araddr >= ACC_OFS_TRIM
                   && araddr < ACC_OFS_TRIM + 12'(4 * ACC_NTRIM)
                   && ridx < 5'(ACC_NTRIM)) begin
        next_s.rdata[7:0] = s.trim[ridx*8 +: 8];
      end else begin
        next_s.rresp = ACC_SLVERR;
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // reset enters foreground calibration, as after power-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.st      <= ACC_FG_CAL;
      s.srcdly  <= ACC_RST_SRCDLY;
      s.muxdly  <= ACC_RST_MUXDLY;
      s.trim    <= {ACC_NTRIM{ACC_RST_TRIM}};
      s.chan    <= {4{ACC_MID_CODE}};
      s.busy    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign awready           = s.awready;
  assign wready            = s.wready;
  assign bvalid            = s.bvalid;
  assign bresp             = s.bresp;
  assign arready           = s.arready;
  assign rvalid            = s.rvalid;
  assign rdata             = s.rdata;
  assign rresp             = s.rresp;
  assign channel_data      = s.chan;
  assign core_cal_active   = s.cal_act;
  assign core_online       = s.online;
  assign offset_cal_active = s.os_act;
  assign cal_busy          = s.busy;

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_MID: assert property (@(posedge aclk) disable iff (!aresetn)
    s.st == ACC_FG_CAL |=> channel_data == {4{ACC_MID_CODE}})
    else $error("output not mid-code in foreground");
  AST_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
    s.st == ACC_BG_CAL |=> $onehot0(core_cal_active))
    else $error("more than one core calibrating");
  AST_SWAP: assert property (@(posedge aclk) disable iff (!aresetn)
    s.st == ACC_BG_CAL && $changed(s.rot) |-> $past(sample_strobe))
    else $error("swap off a sample boundary");
  AST_TRIG: assert property (@(posedge aclk) disable iff (!aresetn)
    s.st == ACC_RUN && !s.bg_en && trig_rise |=> s.st == ACC_FG_CAL)
    else $error("trigger did not start calibration");
  AST_BRESP: assert property (@(posedge aclk) disable iff (!aresetn)
    s.aw_got && s.w_got && !s.bvalid |=> bvalid)
    else $error("write response missing");
  AST_LIVE: assert property (@(posedge aclk) disable iff (!aresetn)
    s.st == ACC_BG_CAL |=> $countones(core_online) == 4)
    else $error("lane left without a core in background");
endmodule : acc_calib

//--- hw/acc_pkg.sv
// Function
// - two modes, foreground and background, plus offset
// - foreground calibration forces output to mid-code
// - six cores, four active, two spares
// - foreground map A0 B1 C4 D5
// - core 2 spares 0/1, core 3 spares 4/5
// - calibrate linearity, gain, offset per core
// - foreground calibration always after power-up
// - trigger from pin or software, selectable
// - background mode never interrupts output data
// - calibrated spare replaces next active, forever
// - only one core calibrated at once in background; foreground calibrates cores 0,1,4,5 together
// - inputs may be driven; offset needs no DC
// - per-channel per-core trims readable and writable
// - foreground offset calibration runs once per sequence
package acc_pkg;
  // ****************************************************************
  // register map, byte addresses of aligned words
  // ****************************************************************
  localparam logic [11:0] ACC_OFS_CTRL   = 12'h000;
  localparam logic [11:0] ACC_OFS_STATUS = 12'h004;
  // delay registers keep their index; the word sits at four times it,
  // since an odd index cannot be an aligned byte address
  localparam logic [9:0]  ACC_IDX_SRCDLY = 10'h09a;
  localparam logic [9:0]  ACC_IDX_MUXDLY = 10'h09b;
  localparam logic [11:0] ACC_OFS_SRCDLY = {ACC_IDX_SRCDLY, 2'b00};
  localparam logic [11:0] ACC_OFS_MUXDLY = {ACC_IDX_MUXDLY, 2'b00};
  localparam logic [11:0] ACC_OFS_TRIM   = 12'h100;
  // ctrl field positions
  localparam int ACC_B_SWTRIG = 0;
  localparam int ACC_B_TRGSEL = 1;
  localparam int ACC_B_BGEN   = 2;
  localparam int ACC_B_FGOS   = 3;
  localparam int ACC_B_BGOS   = 4;
  // reset values
  localparam logic [7:0]  ACC_RST_SRCDLY = 8'h00;
  localparam logic [7:0]  ACC_RST_MUXDLY = 8'h00;
  localparam logic [7:0]  ACC_RST_TRIM   = 8'h80;
  localparam logic [11:0] ACC_MID_CODE   = 12'h000;
  // cycle, core and trim counts
  localparam int ACC_CAL_CYCLES = 64;
  localparam int ACC_OS_CYCLES  = 16;
  localparam int ACC_NCORE      = 6;
  localparam int ACC_NTRIM      = 18;
  // axi responses
  localparam logic [1:0] ACC_OKAY   = 2'b00;
  localparam logic [1:0] ACC_SLVERR = 2'b10;
  typedef enum logic [3:0] {
    ACC_FG_CAL = 4'b0001,
    ACC_FG_OS  = 4'b0010,
    ACC_RUN    = 4'b0100,
    ACC_BG_CAL = 4'b1000
  } acc_state_t;
endpackage : acc_pkg

//--- testbench/acc_host_model.sv
`timescale 1ns/10ps
module acc_host_model (
  input  wire logic        aclk,
  output logic             sample_strobe,
  output logic [47:0]      core_data
);
  // ****************************************
  // analog side: six cores sampling inputs
  // ****************************************
  logic [2:0] phase = 3'h0;
  initial core_data = 48'h0;
  // one sample boundary every eight clocks
  assign sample_strobe = (phase == 3'h0);
  // codes change mid-period so they are steady at every boundary;
  // core number in the top nibble keeps the cores distinguishable
  always @(posedge aclk) begin
    phase <= phase + 3'h1;
    if (phase == 3'h3) begin
      for (int k = 0; k < 6; k++) begin
        core_data[12*k +: 12] <= {k[3:0], 8'($urandom_range(255, 1))};
      end
    end
  end
endmodule : acc_host_model

//--- testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import acc_pkg::*;
  // ****************************************
  // signals and bench state
  // ****************************************
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        cal_trigger_pin, sample_strobe, offset_cal_active, cal_busy;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [47:0] core_data, channel_data;
  logic [5:0]  core_cal_active, core_online, seen;
  logic        hit, os;
  int          errors, total_checks;
  int          fg_map[4] = '{0, 1, 4, 5};
  logic [11:0] ra[4] = '{ACC_OFS_SRCDLY, ACC_OFS_MUXDLY, ACC_OFS_TRIM,
                         ACC_OFS_TRIM + 12'h044};
  logic [7:0]  rv[4] = '{ACC_RST_SRCDLY, ACC_RST_MUXDLY, ACC_RST_TRIM,
                         ACC_RST_TRIM};
  logic [7:0]  wv[4] = '{8'h1f, 8'h1e, 8'h5a, 8'ha5};
  logic [31:0] ctl[4] = '{32'h0, 32'h1, 32'h2, 32'h9};

  // shorter calibration keeps each sequence a few strobes long
  acc_calib #(.CAL_CYCLES(32)) dut (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .cal_trigger_pin, .sample_strobe, .core_data, .channel_data,
    .core_cal_active, .core_online, .offset_cal_active, .cal_busy);
  acc_host_model host (.aclk, .sample_strobe, .core_data);

  // clock at 200 MHz
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one bus transfer; nonblocking drives at the rising edge keep the bench from racing the DUT
  task automatic axi(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end while (!(wr ? bvalid : rvalid));
    r = wr ? bresp : rresp;
    q = rdata;
    bready <= 1'b0;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi

  // lanes after a boundary: 0 fixed map, 1 rotating, 2 mid-code
  task automatic lanes_chk(input int mode);
    logic [11:0] got, e;
    do @(posedge aclk); while (!sample_strobe);
    @(posedge aclk);
    #1;
    for (int l = 0; l < 4; l++) begin
      got = channel_data[12*l +: 12];
      e = (mode == 2) ? 12'h000 : core_data[12*fg_map[l] +: 12];
      for (int k = 0; k < 3; k++)
        if (mode == 1 && got === core_data[12*(3*(l/2)+k) +: 12]) e = got;
      chk(48'(got), 48'(e));
    end
  endtask : lanes_chk

  task automatic wait_idle;
    for (int n = 0; n < 600 && cal_busy !== 1'b0; n++) begin
      @(posedge aclk);
      os |= offset_cal_active;
    end
    chk(48'(cal_busy), 48'h0);
  endtask : wait_idle

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // hang guard, well beyond the expected length of the run
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    summarize();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, cal_trigger_pin} = '0;
    wstrb = 4'hf;
    void'($urandom(43999));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk(48'(cal_busy), 48'h1);
    chk(48'(core_online), 48'h0);
    lanes_chk(2);
    wait_idle();
    lanes_chk(0);
    chk(48'(core_online), 48'h33);
    // reset values, then the recommended swap delays and trims
    for (int i = 0; i < 4; i++) begin
      axi(1'b0, ra[i], 32'h0);
      chk(48'(q[7:0]), 48'(rv[i]));
      axi(1'b1, ra[i], 32'(wv[i]));
      axi(1'b0, ra[i], 32'h0);
      chk(48'(q[7:0]), 48'(wv[i]));
    end
    axi(1'b1, 12'h200, 32'h1);
    chk(48'(r), 48'(ACC_SLVERR));
    axi(1'b0, 12'h200, 32'h0);
    chk(48'(r), 48'(ACC_SLVERR));
    // none, software, pin, software with offset; pin high in every case
    for (int m = 0; m < 4; m++) begin
      axi(1'b1, ACC_OFS_CTRL, ctl[m]);
      cal_trigger_pin <= 1'b1;
      hit = 1'b0;
      os = 1'b0;
      for (int n = 0; n < 20; n++) begin
        @(posedge aclk);
        hit |= cal_busy;
        os |= offset_cal_active;
      end
      cal_trigger_pin <= 1'b0;
      chk(48'(hit), 48'(m != 0));
      if (cal_busy) lanes_chk(2);
      wait_idle();
      chk(48'(os), 48'(ctl[m][3]));
      axi(1'b1, ACC_OFS_CTRL, 32'h0);
    end
    // background: enable, select software, trigger
    axi(1'b1, ACC_OFS_CTRL, 32'h5);
    seen = 6'h0;
    for (int n = 0; n < 500; n++) begin
      lanes_chk(1);
      seen |= core_cal_active;
      chk(48'($countones(core_cal_active) <= 1), 48'h1);
      chk(48'($countones(core_online)), 48'h4);
    end
    chk(48'(seen), 48'h3f);
    summarize();
  end
endmodule : tb_top
